// ---- src/tmb_consts.vh ----
// Purpose: constants for the type-B timer control, configuration and interrupt block
// Assumes: 8-bit register port, byte offsets as printed, one clock of 200 MHz
// Notes: 16-bit registers go through the shared high-byte buffer
`ifndef TMB_CONSTS_VH
`define TMB_CONSTS_VH

// register byte offsets
`define TMB_OFS_CONTROL_PRIMARY   4'h0
`define TMB_OFS_CONTROL_SECONDARY 4'h1
`define TMB_OFS_EVENT_CONTROL     4'h4
`define TMB_OFS_INT_ENABLE        4'h5
`define TMB_OFS_INT_FLAG          4'h6
`define TMB_OFS_RUN_STATE         4'h7
`define TMB_OFS_DEBUG_BEHAVIOUR   4'h8
`define TMB_OFS_HIGH_BUFFER       4'h9
`define TMB_OFS_COUNTER_LO        4'ha
`define TMB_OFS_COUNTER_HI        4'hb
`define TMB_OFS_COMPARE_LO        4'hc
`define TMB_OFS_COMPARE_HI        4'hd

// writable bit masks, everything else reads zero
`define TMB_MASK_CONTROL_PRIMARY   8'h57
`define TMB_MASK_CONTROL_SECONDARY 8'h77
`define TMB_MASK_EVENT_CONTROL     8'h51
`define TMB_MASK_SINGLE_BIT        8'h01

// field positions
`define TMB_BIT_ENABLE         0
`define TMB_BIT_CLOCK_SOURCE_SELECT_LO      1
`define TMB_BIT_SYNC_RESTART   4
`define TMB_BIT_RUN_STANDBY    6
`define TMB_BIT_OUTPUT_ENABLE  4
`define TMB_BIT_PIN_INITIAL    5
`define TMB_BIT_OUTPUT_START_A 6
`define TMB_BIT_EVENT_INPUT_EN 0
`define TMB_BIT_EVENT_EDGE     4
`define TMB_BIT_FILTER         6

// clock select codes
`define TMB_CLK_PERIPHERAL 2'h0
`define TMB_CLK_HALF       2'h1
`define TMB_CLK_COMPANION  2'h2
`define TMB_CLK_RESERVED   2'h3

// timer modes
`define TMB_MODE_PERIODIC  3'h0
`define TMB_MODE_TIMEOUT   3'h1
`define TMB_MODE_CAPTURE   3'h2
`define TMB_MODE_FREQ      3'h3
`define TMB_MODE_PULSE     3'h4
`define TMB_MODE_FREQ_PW   3'h5
`define TMB_MODE_SINGLE    3'h6
`define TMB_MODE_PWM8      3'h7

// reset values and filter length
`define TMB_RESET_BYTE   8'h00
`define TMB_RESET_WORD   16'h0000
`define TMB_FILTER_TAPS  4

`endif

// ---- src/tmb_timer.v ----
// Purpose: control, configuration and interrupt layer of a 16-bit type-B timer
// Assumes: registers on a plain strobe port, read data one cycle after the strobe
// Notes: companion timer supplies a count tick and a restart pulse on this clock
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "tmb_consts.vh"

module tmb_timer (
  // clock, reset, freeze
  input  wire       mclk_in,
  input  wire       reset_in,
  input  wire       clk_en_in,
  // register port
  input  wire [3:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  output reg  [7:0] reg_rdata_out,
  // event system channel, asynchronous to this clock
  input  wire       event_in,
  // companion timer, same clock
  input  wire       companion_tick_in,
  input  wire       companion_restart_in,
  // system state
  input  wire       sleep_powerdown_in,
  input  wire       sleep_standby_in,
  input  wire       debug_break_in,
  // outputs
  output wire       irq_out,
  output wire       wave_out,
  output wire       run_out
);

  // register storage
  reg  [7:0]  control_primary_reg;
  reg  [7:0]  control_secondary_reg;
  reg  [7:0]  event_input_control_reg;
  reg  [7:0]  interrupt_enable_reg;
  reg         interrupt_flag_reg;
  reg  [7:0]  debug_behaviour_reg;
  reg  [7:0]  high_buffer_reg;
  reg  [7:0]  high_buffer_next;
  reg  [15:0] counter_value_reg;
  reg  [15:0] counter_value_next;
  reg  [15:0] compare_capture_reg;
  reg  [15:0] compare_capture_next;
  reg  [7:0]  rdata_next;

  // timing state
  reg         half_div_reg;
  reg         run_reg;
  reg         run_next;
  reg  [1:0]  phase_reg;
  reg  [1:0]  phase_next;
  reg         wave_reg;
  reg         wave_next;
  reg         flag_set;

  // event path
  reg         ev_meta_reg;
  reg         ev_sync_reg;
  reg  [3:0]  ev_taps_reg;
  reg         ev_level_reg;
  reg         ev_prev_reg;

  // field views
  wire        enable_bit     = control_primary_reg[`TMB_BIT_ENABLE];
  wire [1:0]  clock_source_select = control_primary_reg[`TMB_BIT_CLOCK_SOURCE_SELECT_LO+1:`TMB_BIT_CLOCK_SOURCE_SELECT_LO];
  wire        sync_restart   = control_primary_reg[`TMB_BIT_SYNC_RESTART];
  wire        run_in_standby = control_primary_reg[`TMB_BIT_RUN_STANDBY];
  wire [2:0]  timer_mode     = control_secondary_reg[2:0];
  wire        output_enable  = control_secondary_reg[`TMB_BIT_OUTPUT_ENABLE];
  wire        pin_initial_level = control_secondary_reg[`TMB_BIT_PIN_INITIAL];
  wire        output_start_a = control_secondary_reg[`TMB_BIT_OUTPUT_START_A];
  wire        event_input_enable = event_input_control_reg[`TMB_BIT_EVENT_INPUT_EN];
  wire        edge_sel       = event_input_control_reg[`TMB_BIT_EVENT_EDGE];
  wire        filter_on      = event_input_control_reg[`TMB_BIT_FILTER];
  wire        debug_run      = debug_behaviour_reg[0];

  // capture modes clear the flag when the capture high byte is read
  function is_capture_mode;
    input [2:0] mode;
    begin
      is_capture_mode = (mode >= `TMB_MODE_CAPTURE) && (mode <= `TMB_MODE_FREQ_PW);
    end
  endfunction

  // modes whose counter runs without waiting for an event
  function is_free_running;
    input [2:0] mode;
    begin
      is_free_running = (mode != `TMB_MODE_TIMEOUT) && (mode != `TMB_MODE_FREQ_PW) &&
                        (mode != `TMB_MODE_SINGLE);
    end
  endfunction

  // operating conditions
  wire halt_standby = sleep_standby_in && !run_in_standby &&
                      (clock_source_select != `TMB_CLK_COMPANION);
  wire halt_debug   = debug_break_in && !debug_run;
  wire operate      = enable_bit && !sleep_powerdown_in && !halt_standby &&
                      !halt_debug;

  // count tick from the selected source; reserved code never ticks
  reg tick;
  always @* begin
    case (clock_source_select)
      `TMB_CLK_PERIPHERAL: tick = 1'b1;
      `TMB_CLK_HALF:       tick = half_div_reg;
      `TMB_CLK_COMPANION:  tick = companion_tick_in;
      default:             tick = 1'b0;
    endcase
  end

  // event edges, gated by enable so a disabled input does nothing
  wire ev_rise  = ev_level_reg && !ev_prev_reg;
  wire ev_fall  = !ev_level_reg && ev_prev_reg;
  wire ev_go    = operate && event_input_enable;
  wire ev_start = ev_go && (edge_sel ? ev_fall : ev_rise);
  wire ev_other = ev_go && (edge_sel ? ev_rise : ev_fall);
  wire ev_any   = ev_go && (ev_rise || ev_fall);

  // bus decode
  wire wr_ctl_a   = reg_wr_in && (reg_addr_in == `TMB_OFS_CONTROL_PRIMARY);
  wire wr_ctl_b   = reg_wr_in && (reg_addr_in == `TMB_OFS_CONTROL_SECONDARY);
  wire wr_event   = reg_wr_in && (reg_addr_in == `TMB_OFS_EVENT_CONTROL);
  wire wr_ie      = reg_wr_in && (reg_addr_in == `TMB_OFS_INT_ENABLE);
  wire wr_flag    = reg_wr_in && (reg_addr_in == `TMB_OFS_INT_FLAG);
  wire wr_dbg     = reg_wr_in && (reg_addr_in == `TMB_OFS_DEBUG_BEHAVIOUR);
  wire wr_buf     = reg_wr_in && (reg_addr_in == `TMB_OFS_HIGH_BUFFER);
  wire wr_cnt_lo  = reg_wr_in && (reg_addr_in == `TMB_OFS_COUNTER_LO);
  wire wr_cnt_hi  = reg_wr_in && (reg_addr_in == `TMB_OFS_COUNTER_HI);
  wire wr_cmp_lo  = reg_wr_in && (reg_addr_in == `TMB_OFS_COMPARE_LO);
  wire wr_cmp_hi  = reg_wr_in && (reg_addr_in == `TMB_OFS_COMPARE_HI);
  wire rd_cnt_lo  = reg_rd_in && (reg_addr_in == `TMB_OFS_COUNTER_LO);
  wire rd_cmp_lo  = reg_rd_in && (reg_addr_in == `TMB_OFS_COMPARE_LO);
  wire rd_cmp_hi  = reg_rd_in && (reg_addr_in == `TMB_OFS_COMPARE_HI);

  // flag clears by a one-write or by reading the capture in a capture mode
  wire flag_clear = (wr_flag && reg_wdata_in[0]) ||
                    (rd_cmp_hi && is_capture_mode(timer_mode));

  wire run_state = operate && (is_free_running(timer_mode) || run_reg);
  wire at_top    = (counter_value_reg == compare_capture_reg);
  wire [15:0] count_up = counter_value_reg + 16'h0001;
  wire [7:0]  pwm_lo_up = counter_value_reg[7:0] + 8'h01;

  // mode engine: counter, capture, run and output level
  always @* begin
    counter_value_next   = counter_value_reg;
    compare_capture_next = compare_capture_reg;
    run_next             = run_reg;
    phase_next           = phase_reg;
    wave_next            = wave_reg;
    flag_set             = 1'b0;
    if (operate) begin
      case (timer_mode)
        `TMB_MODE_PERIODIC: begin
          if (tick) begin
            if (at_top) begin
              counter_value_next = `TMB_RESET_WORD;
              flag_set = 1'b1;
            end else begin
              counter_value_next = count_up;
            end
          end
        end
        `TMB_MODE_TIMEOUT: begin
          if (ev_start) begin
            run_next = 1'b1;
            counter_value_next = `TMB_RESET_WORD;
          end else if (ev_other) begin
            run_next = 1'b0;
          end else if (run_reg && tick) begin
            if (at_top) begin
              counter_value_next = `TMB_RESET_WORD;
              flag_set = 1'b1;
            end else begin
              counter_value_next = count_up;
            end
          end
        end
        `TMB_MODE_CAPTURE, `TMB_MODE_FREQ: begin
          if (ev_start) begin
            compare_capture_next = counter_value_reg;
            flag_set = 1'b1;
            if (timer_mode == `TMB_MODE_FREQ) begin
              counter_value_next = `TMB_RESET_WORD;
            end else if (tick) begin
              counter_value_next = count_up;
            end
          end else if (tick) begin
            counter_value_next = count_up;
          end
        end
        `TMB_MODE_PULSE: begin
          if (ev_start) begin
            counter_value_next = `TMB_RESET_WORD;
          end else if (ev_other) begin
            compare_capture_next = counter_value_reg;
            flag_set = 1'b1;
          end else if (tick) begin
            counter_value_next = count_up;
          end
        end
        `TMB_MODE_FREQ_PW: begin
          // phase 0 waits, 1 counts to capture, 2 counts to stop, 3 waits for clear
          case (phase_reg)
            2'd0: begin
              if (ev_start) begin
                counter_value_next = `TMB_RESET_WORD;
                run_next = 1'b1;
                phase_next = 2'd1;
              end
            end
            2'd1: begin
              if (ev_other) begin
                compare_capture_next = counter_value_reg;
                phase_next = 2'd2;
              end else if (tick) begin
                counter_value_next = count_up;
              end
            end
            2'd2: begin
              if (ev_start) begin
                run_next = 1'b0;
                flag_set = 1'b1;
                phase_next = 2'd3;
              end else if (tick) begin
                counter_value_next = count_up;
              end
            end
            default: begin
              if (!interrupt_flag_reg) begin
                phase_next = 2'd0;
              end
            end
          endcase
        end
        `TMB_MODE_SINGLE: begin
          if (!run_reg) begin
            wave_next = 1'b0;
            // events while the output is low after a stop are only taken when idle
            if ((edge_sel ? ev_any : ev_rise && ev_go)) begin
              run_next = 1'b1;
              counter_value_next = `TMB_RESET_WORD;
              wave_next = output_start_a;
            end
          end else begin
            wave_next = 1'b1;
            if (tick) begin
              if (at_top) begin
                run_next = 1'b0;
                wave_next = 1'b0;
                flag_set = 1'b1;
              end else begin
                counter_value_next = count_up;
              end
            end
          end
        end
        `TMB_MODE_PWM8: begin
          if (tick) begin
            if (counter_value_reg[7:0] == compare_capture_reg[7:0]) begin
              counter_value_next = `TMB_RESET_WORD;
            end else begin
              counter_value_next = {8'h00, pwm_lo_up};
            end
            if (counter_value_reg[7:0] == compare_capture_reg[15:8]) begin
              flag_set = 1'b1;
            end
          end
          wave_next = (compare_capture_reg[7:0] != 8'h00) &&
                      (counter_value_reg[7:0] < compare_capture_reg[15:8]);
        end
        default: begin
          counter_value_next = counter_value_reg;
        end
      endcase
      if (sync_restart && companion_restart_in) begin
        counter_value_next = `TMB_RESET_WORD;
      end
    end else if (!enable_bit) begin
      run_next = 1'b0;
      phase_next = 2'd0;
      wave_next = 1'b0;
    end
    // software writes through the high-byte buffer override the engine
    if (wr_cnt_hi) begin
      counter_value_next = {reg_wdata_in, high_buffer_reg};
    end
    if (wr_cmp_hi) begin
      compare_capture_next = {reg_wdata_in, high_buffer_reg};
    end
  end

  // output: initial level outside single-shot and 8-bit PWM modes, forced zero without output enable
  wire mode_level = (timer_mode == `TMB_MODE_SINGLE) ? wave_reg :
                    (timer_mode == `TMB_MODE_PWM8) ? wave_reg :
                    pin_initial_level;
  assign wave_out = output_enable ? mode_level : 1'b0;
  assign irq_out  = interrupt_enable_reg[0] && interrupt_flag_reg;
  assign run_out  = run_state;

  // high-byte buffer: low read latches the high half, low write parks data
  always @* begin
    high_buffer_next = high_buffer_reg;
    if (wr_buf || wr_cnt_lo || wr_cmp_lo) begin
      high_buffer_next = reg_wdata_in;
    end else if (rd_cnt_lo) begin
      high_buffer_next = counter_value_reg[15:8];
    end else if (rd_cmp_lo) begin
      high_buffer_next = compare_capture_reg[15:8];
    end
  end

  // read mux; unmapped offsets and reserved bits answer zero
  always @* begin
    rdata_next = `TMB_RESET_BYTE;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `TMB_OFS_CONTROL_PRIMARY:   rdata_next = control_primary_reg;
        `TMB_OFS_CONTROL_SECONDARY: rdata_next = control_secondary_reg;
        `TMB_OFS_EVENT_CONTROL:     rdata_next = event_input_control_reg;
        `TMB_OFS_INT_ENABLE:        rdata_next = interrupt_enable_reg;
        `TMB_OFS_INT_FLAG:          rdata_next = {7'h00, interrupt_flag_reg};
        `TMB_OFS_RUN_STATE:         rdata_next = {7'h00, run_state};
        `TMB_OFS_DEBUG_BEHAVIOUR:   rdata_next = debug_behaviour_reg;
        `TMB_OFS_HIGH_BUFFER:       rdata_next = high_buffer_reg;
        `TMB_OFS_COUNTER_LO:        rdata_next = counter_value_reg[7:0];
        `TMB_OFS_COUNTER_HI:        rdata_next = high_buffer_reg;
        `TMB_OFS_COMPARE_LO:        rdata_next = compare_capture_reg[7:0];
        `TMB_OFS_COMPARE_HI:        rdata_next = high_buffer_reg;
        default:                    rdata_next = `TMB_RESET_BYTE;
      endcase
    end
  end

  // event synchroniser and noise canceller; filter adds four cycles of delay
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ev_meta_reg  <= 1'b0;
      ev_sync_reg  <= 1'b0;
      ev_taps_reg  <= 4'h0;
      ev_level_reg <= 1'b0;
      ev_prev_reg  <= 1'b0;
    end else if (clk_en_in) begin
      ev_meta_reg <= event_in;
      ev_sync_reg <= ev_meta_reg;
      ev_taps_reg <= {ev_taps_reg[2:0], ev_sync_reg};
      ev_prev_reg <= ev_level_reg;
      if (!filter_on) begin
        ev_level_reg <= ev_sync_reg;
      end else if (ev_taps_reg == 4'hf) begin
        ev_level_reg <= 1'b1;
      end else if (ev_taps_reg == 4'h0) begin
        ev_level_reg <= 1'b0;
      end
    end
  end

  // register file and timer state
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      control_primary_reg     <= `TMB_RESET_BYTE;
      control_secondary_reg   <= `TMB_RESET_BYTE;
      event_input_control_reg <= `TMB_RESET_BYTE;
      interrupt_enable_reg    <= `TMB_RESET_BYTE;
      interrupt_flag_reg      <= 1'b0;
      debug_behaviour_reg     <= `TMB_RESET_BYTE;
      high_buffer_reg         <= `TMB_RESET_BYTE;
      counter_value_reg       <= `TMB_RESET_WORD;
      compare_capture_reg     <= `TMB_RESET_WORD;
      reg_rdata_out           <= `TMB_RESET_BYTE;
      half_div_reg            <= 1'b0;
      run_reg                 <= 1'b0;
      phase_reg               <= 2'd0;
      wave_reg                <= 1'b0;
    end else if (clk_en_in) begin
      if (wr_ctl_a) begin
        control_primary_reg <= reg_wdata_in & `TMB_MASK_CONTROL_PRIMARY;
      end
      if (wr_ctl_b) begin
        control_secondary_reg <= reg_wdata_in & `TMB_MASK_CONTROL_SECONDARY;
      end
      if (wr_event) begin
        event_input_control_reg <= reg_wdata_in & `TMB_MASK_EVENT_CONTROL;
      end
      if (wr_ie) begin
        interrupt_enable_reg <= reg_wdata_in & `TMB_MASK_SINGLE_BIT;
      end
      if (wr_dbg) begin
        debug_behaviour_reg <= reg_wdata_in & `TMB_MASK_SINGLE_BIT;
      end
      // a new event in the clearing cycle wins over the clear
      interrupt_flag_reg  <= flag_set || (interrupt_flag_reg && !flag_clear);
      high_buffer_reg     <= high_buffer_next;
      counter_value_reg   <= counter_value_next;
      compare_capture_reg <= compare_capture_next;
      reg_rdata_out       <= rdata_next;
      half_div_reg        <= operate ? !half_div_reg : 1'b0;
      run_reg             <= run_next;
      phase_reg           <= phase_next;
      wave_reg            <= wave_next;
    end
  end

endmodule // tmb_timer

// ---- test/tmb_timer_chk.sv ----
// Purpose: port checker for the type-B timer
// Assumes: clk_en_in held high by the bench
// Notes: mirrors of three control bits stand in for hidden registers
`timescale 1ns/1ps
module tmb_timer_chk (
  // clock, reset, sleep
  input wire       mclk_in,
  input wire       reset_in,
  input wire       sleep_powerdown_in,
  // register port
  input wire [3:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire [7:0] reg_rdata_out,
  // outputs
  input wire       irq_out,
  input wire       wave_out,
  input wire       run_out
);
  reg en_reg;
  reg ie_reg;
  reg oe_reg;
  // mirrors follow accepted writes, so port relations can be stated
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      en_reg <= 1'b0;
      ie_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == 4'h0) en_reg <= reg_wdata_in[0];
      if (reg_addr_in == 4'h5) ie_reg <= reg_wdata_in[0];
      if (reg_addr_in == 4'h1) oe_reg <= reg_wdata_in[4];
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  irq_needs_en_a: assert property (irq_out |-> ie_reg)
    else $error("request while source disabled");
  irq_holds_a: assert property (irq_out && !reg_wr_in && !reg_rd_in |=> irq_out)
    else $error("request dropped without a clear");
  rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");
  unmapped_zero_a: assert property (reg_rd_in && reg_addr_in[3:1] inside {3'h1, 3'h7}
    |=> reg_rdata_out == 8'h00) else $error("reserved offset not zero");
  run_read_a: assert property (reg_rd_in && reg_addr_in == 4'h7
    |=> reg_rdata_out == {7'h00, $past(run_out)}) else $error("run status read wrong");
  wave_forced_a: assert property (!oe_reg |-> !wave_out)
    else $error("output not forced low");
  run_needs_en_a: assert property (!en_reg |-> !run_out)
    else $error("running while disabled");
  powerdown_hold_a: assert property (sleep_powerdown_in && $past(sleep_powerdown_in)
    && !$past(reg_wr_in) && !$past(reg_rd_in) |-> $stable(irq_out))
    else $error("active in power-down");
endmodule // tmb_timer_chk

bind tmb_timer tmb_timer_chk tmb_timer_chk_i (.mclk_in(mclk_in), .reset_in(reset_in),
  .sleep_powerdown_in(sleep_powerdown_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .wave_out(wave_out), .run_out(run_out));

// ---- test/tmb_far_model.sv ----
// Purpose: far-side model of the event channel and companion timer
// Assumes: both share the timer clock
// Notes: companion ticks every fourth cycle; restart only when asked
`timescale 1ns/1ps
module tmb_far_model (
  // clock and reset
  input  wire mclk_in,
  input  wire reset_in,
  // bench requests
  input  wire ev_req_in,
  input  wire restart_req_in,
  // toward the timer
  output reg  event_out,
  output reg  tick_out,
  output reg  restart_out
);
  reg [1:0] div_reg;
  // everything changes just after the edge, as the real sources do
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      div_reg     <= 2'h0;
      event_out   <= 1'b0;
      tick_out    <= 1'b0;
      restart_out <= 1'b0;
    end else begin
      div_reg     <= div_reg + 2'h1;
      event_out   <= ev_req_in;
      tick_out    <= (div_reg == 2'h3);
      restart_out <= restart_req_in;
    end
  end
endmodule // tmb_far_model

// ---- test/timer_b_control_and_irq_test.sv ----
// Purpose: self-checking bench for the type-B timer
// Assumes: far model supplies event and companion pulses
// Notes: count deltas are taken between reads 64 cycles apart
`timescale 1ns/1ps
`include "tmb_consts.vh"
module timer_b_control_and_irq_test;
  reg        mclk_in = 1'b0;
  reg        reset_in = 1'b1;
  reg  [3:0] addr = 4'h0;
  reg  [7:0] wdata = 8'h00;
  reg        wr_s = 1'b0;
  reg        rd_s = 1'b0;
  reg        pd = 1'b0;
  reg        sb = 1'b0;
  reg        dbg = 1'b0;
  reg        ev_req = 1'b0;
  reg        rst_req = 1'b0;
  wire [7:0] rdata;
  wire       ev, tick, rst, irq, wave, run;
  int        failures = 0;
  int        cmp_count = 0;
  int        i;
  reg  [7:0] b;
  reg [15:0] c0, c1, v;
  tmb_far_model tmb_far_model_i (.mclk_in(mclk_in), .reset_in(reset_in), .ev_req_in(ev_req),
    .restart_req_in(rst_req), .event_out(ev), .tick_out(tick), .restart_out(rst));
  tmb_timer tmb_timer_i (.mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(1'b1),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
    .reg_rdata_out(rdata), .event_in(ev), .companion_tick_in(tick),
    .companion_restart_in(rst), .sleep_powerdown_in(pd), .sleep_standby_in(sb),
    .debug_break_in(dbg), .irq_out(irq), .wave_out(wave), .run_out(run));
  // 200 MHz clock
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  task automatic check(input [15:0] seen, input [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one idle cycle after each strobe keeps every signal to one change per step
  task automatic wr(input [3:0] a, input [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk_in);
    wr_s <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rd(input [3:0] a, output [7:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk_in);
    rd_s <= 1'b0;
    #1 d = rdata;
    @(posedge mclk_in);
  endtask
  task automatic wr16(input [3:0] a, input [15:0] d);
    wr(a, d[7:0]);
    wr(a + 4'h1, d[15:8]);
  endtask
  task automatic rd16(input [3:0] a, output [15:0] d);
    rd(a, d[7:0]);
    rd(a + 4'h1, d[15:8]);
  endtask
  task automatic wait_irq(input int n);
    for (int k = 0; k < n && irq !== 1'b1; k++) @(posedge mclk_in);
    if (irq !== 1'b1) begin
      failures++;
      stop_test();
    end
  endtask
  // read-back value of a register written with all ones
  function automatic [7:0] kept(input [3:0] a);
    case (a)
      4'h1: kept = `TMB_MASK_CONTROL_SECONDARY;
      4'h4: kept = `TMB_MASK_EVENT_CONTROL;
      4'h5, 4'h8: kept = `TMB_MASK_SINGLE_BIT;
      4'h9: kept = 8'hff;
      default: kept = 8'h00;
    endcase
  endfunction
  // counter advance over 64 cycles under one clock and sleep setting
  task automatic delta(input [7:0] ctl, input [2:0] slp, input [15:0] exp);
    {pd, sb, dbg} <= slp;
    wr16(4'ha, 16'h0000);
    wr(4'h0, ctl);
    rd16(4'ha, c0);
    repeat (60) @(posedge mclk_in);
    rd16(4'ha, c1);
    check(c1 - c0, exp);
    wr(4'h0, 8'h00);
  endtask
  initial begin
    void'($urandom(32'h7fc3));
    repeat (20) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    for (i = 0; i < 16; i++) begin
      rd(i[3:0], b);
      check(b, 8'h00);
    end
    for (i = 1; i < 10; i++) wr(i[3:0], 8'hff);
    for (i = 1; i < 10; i++) begin
      rd(i[3:0], b);
      check(b, kept(i[3:0]));
    end
    for (i = 1; i < 10; i++) wr(i[3:0], 8'h00);
    for (i = 0; i < 8; i++) begin
      v = 16'($urandom);
      wr16(4'hc, v);
      rd16(4'hc, c0);
      check(c0, v);
    end
    wr16(4'hc, 16'hffff);
    delta(8'h01, 3'h0, 16'h0040);
    delta(8'h03, 3'h0, 16'h0020);
    delta(8'h05, 3'h0, 16'h0010);
    delta(8'h07, 3'h0, 16'h0000);
    delta(8'h01, 3'h4, 16'h0000);
    delta(8'h01, 3'h2, 16'h0000);
    delta(8'h41, 3'h2, 16'h0040);
    delta(8'h05, 3'h2, 16'h0010);
    delta(8'h01, 3'h1, 16'h0000);
    wr(4'h8, 8'h01);
    delta(8'h01, 3'h1, 16'h0040);
    wr(4'h8, 8'h00);
    delta(8'h00, 3'h0, 16'h0000);
    // restart from the companion zeroes a long-running count
    wr(4'h0, 8'h11);
    repeat (40) @(posedge mclk_in);
    rst_req <= 1'b1;
    @(posedge mclk_in);
    rst_req <= 1'b0;
    // the restart lands two edges after the request; read only after it
    repeat (2) @(posedge mclk_in);
    rd16(4'ha, c0);
    check(c0 < 16'h0008, 1'b1);
    wr(4'h0, 8'h00);
    // periodic request, masking, holding and clearing
    v = 16'($urandom_range(19, 4));
    wr16(4'hc, v);
    wr16(4'ha, 16'h0000);
    wr(4'h5, 8'h01);
    wr(4'h0, 8'h01);
    check(run, 1'b1);
    wait_irq(v + 8);
    check(irq, 1'b1);
    wr(4'h0, 8'h00);
    wr(4'h5, 8'h00);
    check(irq, 1'b0);
    wr(4'h5, 8'h01);
    repeat (5) @(posedge mclk_in);
    check(irq, 1'b1);
    wr(4'h6, 8'h01);
    check(irq, 1'b0);
    for (i = 0; i < 3; i++) begin
      b = (i == 0) ? 8'h20 : (i == 1) ? 8'h30 : 8'h10;
      wr(4'h1, b);
      wr(4'h0, 8'h01);
      check(wave, b[5] & b[4]);
      wr(4'h0, 8'h00);
    end
    // capture: input disabled, short pulse filtered, then accepted
    wr(4'h1, 8'h02);
    // the short enables above may have hit a small top and set the flag
    wr(4'h6, 8'h01);
    for (i = 0; i < 3; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'h41 : 8'h01;
      wr(4'h4, b);
      wr(4'h0, 8'h01);
      ev_req <= 1'b1;
      repeat (2) @(posedge mclk_in);
      ev_req <= 1'b0;
      repeat (12) @(posedge mclk_in);
      check(irq, i == 2);
      if (i < 2) wr(4'h0, 8'h00);
    end
    rd16(4'hc, c0);
    check(irq, 1'b0);
    wr(4'h0, 8'h00);
    // single shot: output rises with the event or one cycle after it
    wr16(4'hc, 16'h0010);
    for (i = 0; i < 2; i++) begin
      b = (i == 0) ? 8'h56 : 8'h16;
      wr(4'h1, b);
      wr(4'h6, 8'h01);
      wr(4'h0, 8'h01);
      check(wave, 1'b0);
      ev_req <= 1'b1;
      repeat (2) @(posedge mclk_in);
      ev_req <= 1'b0;
      repeat (4) @(posedge mclk_in);
      check(wave, b[6]);
      check(run, 1'b1);
      repeat (24) @(posedge mclk_in);
      check({wave, run, irq}, 3'h1);
      wr(4'h0, 8'h00);
    end
    stop_test();
  end
endmodule // timer_b_control_and_irq_test
